// ### verilog/omb_pkg.sv
// shared constants and helpers for the on-line memory self-test pair
package omb_pkg;
  // ==========================================================
  // sizes
  localparam int AW = 4;
  localparam int DW = 8;
  localparam int NMEM = 2;
  localparam int MSW = 1;
  localparam int PAW = 12;
  localparam int PDW = 32;
  localparam int NPROG = 4;
  localparam int PCW = 2;
  localparam int BURST_LOCS = 2;
  localparam int BURST_MAX_CYC = 20;
  localparam logic [1:0] DRAIN_CYC = 2'h2;
  // ==========================================================
  // register offsets, byte addresses within a 4 KB window
  localparam logic [PAW-1:0] OFS_CTRL = 12'h000;
  localparam logic [PAW-1:0] OFS_STAT = 12'h004;
  localparam logic [PAW-1:0] OFS_ADDR = 12'h008;
  localparam logic [PAW-1:0] OFS_ATTR = 12'h00C;
  localparam logic [PAW-1:0] OFS_PAT = 12'h010;
  localparam logic [PAW-1:0] OFS_EADDR = 12'h014;
  localparam logic [PAW-1:0] OFS_EDATA = 12'h018;
  localparam logic [PAW-1:0] OFS_PROG0 = 12'h020;
  localparam logic [PAW-1:0] OFS_PID = 12'hFE0;
  localparam logic [PAW-1:0] OFS_CID = 12'hFF0;
  // ==========================================================
  // field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_OFFL = 1;
  localparam int CTRL_DOWN = 2;
  localparam int CTRL_IRQEN = 3;
  localparam int CTRL_ARR = 4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ERR = 2;
  localparam int STAT_ARMED = 3;
  localparam int OP_WR = 0;
  localparam int OP_RD = 1;
  localparam int OP_INV = 2;
  localparam int OP_LAST = 3;
  localparam int OPW = 4;
  // ==========================================================
  // reset values; identity words are arbitrary
  localparam logic [DW-1:0] PAT_RST = 8'h55;
  localparam logic [AW-1:0] ADDR_RST = 4'h0;
  localparam logic [AW-1:0] HIGH_RST = 4'hF;
  localparam logic [OPW-1:0] PROG_RST = 4'h0;
  localparam logic [PDW-1:0] PID_VAL = 32'h0000_00A1;
  localparam logic [PDW-1:0] CID_VAL = 32'h0000_00B2;

  function automatic logic [AW-1:0] addr_step(input logic [AW-1:0] a,
      input logic down, input logic [AW-1:0] high);
    if (down) begin
      addr_step = (a == '0) ? high : a - 4'h1;
    end else begin
      addr_step = (a == high) ? '0 : a + 4'h1;
    end
  endfunction

  function automatic logic [DW-1:0] pat_of(input logic [DW-1:0] p,
      input logic inv);
    pat_of = inv ? ~p : p;
  endfunction
endpackage

// ### verilog/omb_if.sv
// test-port link between the self-test controller and the core memories
`timescale 1ns/1ps
`default_nettype none
interface omb_if;
  import omb_pkg::*;
  logic req;
  logic ack;
  logic [MSW-1:0] arr;
  logic [AW-1:0] addr;
  logic we;
  logic re;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  logic rvalid;
  modport ctrl (output req, arr, addr, we, re, wdata,
                input ack, rdata, rvalid);
  modport core (input req, arr, addr, we, re, wdata,
                output ack, rdata, rvalid);
endinterface
`default_nettype wire

// ### verilog/omb_sram.sv
// flip-flop memory array with one registered read port
`timescale 1ns/1ps
`default_nettype none
module omb_sram import omb_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_we,
  input wire logic i_re,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [2**AW];

  // storage itself is not reset, like a real array
  always_ff @(posedge i_sys_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_rdata <= '0;
    end else if (i_re) begin
      o_rdata <= mem[i_addr];
    end
  end
endmodule
`default_nettype wire

// ### verilog/omb_core.sv
// core side: memory lock, processor stall and array muxing
`timescale 1ns/1ps
`default_nettype none
module omb_core import omb_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  omb_if.core mb,
  input wire logic i_cpu_req,
  input wire logic [MSW-1:0] i_cpu_mem,
  input wire logic i_cpu_we,
  input wire logic [AW-1:0] i_cpu_addr,
  input wire logic [DW-1:0] i_cpu_wdata,
  input wire logic [NMEM-1:0] i_mem_off,
  output logic o_cpu_stall,
  output logic o_cpu_refused,
  output logic o_cpu_rvalid,
  output logic [DW-1:0] o_cpu_rdata
);
  logic ack;
  logic cpu_go;
  logic [MSW-1:0] arr_q;
  logic [MSW-1:0] cpu_mem_q;
  logic [DW-1:0] rd [NMEM];

  // ==========================================================
  // lock handshake
  // grant only when the processor is not using that array this cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= mb.req && (ack || !(cpu_go && i_cpu_mem == mb.arr));
    end
  end
  assign mb.ack = ack;

  // only the locked array stalls; the others stay open
  assign o_cpu_stall = i_cpu_req && ack && (i_cpu_mem == mb.arr);
  // an off-line array is switched away from the processor
  assign o_cpu_refused = i_cpu_req && i_mem_off[i_cpu_mem];
  assign cpu_go = i_cpu_req && !o_cpu_stall && !o_cpu_refused;

  // ==========================================================
  // arrays
  for (genvar g = 0; g < NMEM; g++) begin : g_mem
    logic use_mb;
    assign use_mb = ack && (mb.arr == MSW'(g));
    omb_sram u_sram (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_we(use_mb ? mb.we : (cpu_go && i_cpu_we && i_cpu_mem == MSW'(g))),
      .i_re(use_mb ? mb.re : (cpu_go && !i_cpu_we && i_cpu_mem == MSW'(g))),
      .i_addr(use_mb ? mb.addr : i_cpu_addr),
      .i_wdata(use_mb ? mb.wdata : i_cpu_wdata),
      .o_rdata(rd[g])
    );
  end

  // ==========================================================
  // read returns, one cycle after the request
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      mb.rvalid <= 1'b0;
      o_cpu_rvalid <= 1'b0;
      arr_q <= '0;
      cpu_mem_q <= '0;
    end else begin
      mb.rvalid <= ack && mb.re;
      o_cpu_rvalid <= cpu_go && !i_cpu_we;
      arr_q <= mb.arr;
      cpu_mem_q <= i_cpu_mem;
    end
  end
  assign mb.rdata = rd[arr_q];
  assign o_cpu_rdata = rd[cpu_mem_q];
endmodule
`default_nettype wire

// ### verilog/omb_ctrl.sv
// self-test controller: register store, sequencer and read-data checker
`timescale 1ns/1ps
`default_nettype none
// Operation
// - on-line bursts under twenty cycles, two locations
// - save tested locations, restore before burst end
// - address steps itself after each burst
// - core locks only the memory under test
// - core stalls processor access to locked memory
// - request access, no transactions before grant
// - core acknowledges and locks target memory
// - run burst, then withdraw request
// - core unlocks when request drops
// - off-line march covers all entries, destructive; code marches only from the ADDR register value to the end address
// - software disables memory around off-line test
// - error results stay readable after test
// - registers occupy a 4 KB window
// - slave port reads and writes registers
// - configuration, address, data, program, id registers
// - generate transactions from registers, compare reads
// - software reaches only registers, not sequencer
// - interrupt or flag on completion or error
// - no activity until programmed with attributes
// - transactions back to back on core clock
module omb_ctrl import omb_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [PAW-1:0] i_paddr,
  input wire logic [PDW-1:0] i_pwdata,
  output logic [PDW-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_irq,
  output logic o_busy,
  omb_if.ctrl mb
);
  typedef enum logic [2:0] {
    S_IDLE, S_REQ, S_SAVE, S_OPS, S_RESTORE, S_DRAIN
  } omb_state_t;

  omb_state_t state;
  logic offl, down, irq_en, armed;
  logic [MSW-1:0] arr;
  logic [AW-1:0] high, cur_addr, t_addr;
  logic [DW-1:0] pat, err_data;
  logic [AW-1:0] err_addr;
  logic done_st, err_st;
  logic [OPW-1:0] prog [NPROG];
  logic [PCW-1:0] pc;
  logic loc;
  logic [1:0] drain;
  logic [DW-1:0] save [BURST_LOCS];
  logic [DW-1:0] q_exp, p_exp;
  logic q_save, p_save, q_cmp, p_cmp, q_loc, p_loc;
  logic [AW-1:0] p_addr;
  logic wr, rd_setup, start, done_set, err_set, last_op, mapped;
  logic [OPW-1:0] op;
  logic [PDW-1:0] rdata_mux;

  // ==========================================================
  // register access
  assign wr = i_psel && i_penable && i_pwrite;
  assign rd_setup = i_psel && !i_penable && !i_pwrite;
  assign start = wr && i_paddr == OFS_CTRL && i_pwdata[CTRL_START]
                 && state == S_IDLE && armed;
  assign o_pready = 1'b1;
  assign mapped = i_paddr inside {OFS_CTRL, OFS_STAT, OFS_ADDR, OFS_ATTR,
                  OFS_PAT, OFS_EADDR, OFS_EDATA, OFS_PID, OFS_CID}
                  || (i_paddr[PAW-1:4] == OFS_PROG0[PAW-1:4]
                  && i_paddr[1:0] == 2'h0);
  assign o_pslverr = i_psel && i_penable && !mapped;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      offl <= 1'b0;
      down <= 1'b0;
      irq_en <= 1'b0;
      arr <= '0;
    end else if (wr && i_paddr == OFS_CTRL && state == S_IDLE) begin
      offl <= i_pwdata[CTRL_OFFL];
      down <= i_pwdata[CTRL_DOWN];
      irq_en <= i_pwdata[CTRL_IRQEN];
      arr <= i_pwdata[CTRL_ARR +: MSW];
    end
  end

  // attributes must be written before any run is accepted
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      armed <= 1'b0;
      high <= HIGH_RST;
      pat <= PAT_RST;
    end else if (state == S_IDLE && wr) begin
      if (i_paddr == OFS_ATTR) begin
        armed <= 1'b1;
        high <= i_pwdata[AW-1:0];
      end
      if (i_paddr == OFS_PAT) begin
        pat <= i_pwdata[DW-1:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < NPROG; i++) begin
        prog[i] <= PROG_RST;
      end
    end else if (state == S_IDLE && wr
                 && i_paddr[PAW-1:4] == OFS_PROG0[PAW-1:4]) begin
      prog[i_paddr[3:2]] <= i_pwdata[OPW-1:0];
    end
  end

  always_comb begin
    rdata_mux = '0;
    case (i_paddr)
      OFS_CTRL: rdata_mux = PDW'({arr, irq_en, down, offl, 1'b0});
      OFS_STAT: rdata_mux = PDW'({armed, err_st, done_st, o_busy});
      OFS_ADDR: rdata_mux = PDW'(cur_addr);
      OFS_ATTR: rdata_mux = PDW'(high);
      OFS_PAT: rdata_mux = PDW'(pat);
      OFS_EADDR: rdata_mux = PDW'(err_addr);
      OFS_EDATA: rdata_mux = PDW'(err_data);
      OFS_PID: rdata_mux = PID_VAL;
      OFS_CID: rdata_mux = CID_VAL;
      default: begin
        if (i_paddr[PAW-1:4] == OFS_PROG0[PAW-1:4]) begin
          rdata_mux = PDW'(prog[i_paddr[3:2]]);
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_prdata <= '0;
    end else if (rd_setup) begin
      o_prdata <= rdata_mux;
    end
  end

  // ==========================================================
  // sequencer
  assign op = prog[pc];
  assign last_op = op[OP_LAST] || pc == PCW'(NPROG - 1);
  assign done_set = state == S_DRAIN && drain == 2'h0;
  assign o_busy = state != S_IDLE;
  // request stands from start through the drain of the last read
  assign mb.req = state != S_IDLE;
  assign mb.arr = arr;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state <= S_IDLE;
      pc <= '0;
      loc <= 1'b0;
      t_addr <= ADDR_RST;
      drain <= '0;
    end else begin
      case (state)
        S_IDLE: begin
          if (start) begin
            state <= S_REQ;
          end
        end
        S_REQ: begin
          pc <= '0;
          loc <= 1'b0;
          t_addr <= cur_addr;
          if (mb.ack) begin
            state <= offl ? S_OPS : S_SAVE;
          end
        end
        S_SAVE: state <= S_OPS;
        S_OPS: begin
          pc <= last_op ? '0 : pc + 2'h1;
          if (last_op && !offl) begin
            state <= S_RESTORE;
          end else if (last_op) begin
            // from the ADDR start address, end address depends on direction
            if (t_addr == (down ? '0 : high)) begin
              state <= S_DRAIN;
              drain <= DRAIN_CYC;
            end else begin
              t_addr <= addr_step(t_addr, down, high);
            end
          end
        end
        S_RESTORE: begin
          t_addr <= addr_step(t_addr, down, high);
          loc <= 1'b1;
          if (loc) begin
            state <= S_DRAIN;
            drain <= DRAIN_CYC;
          end else begin
            state <= S_SAVE;
          end
        end
        S_DRAIN: begin
          drain <= drain - 2'h1;
          if (drain == 2'h0) begin
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // next burst starts two locations further on
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      cur_addr <= ADDR_RST;
    end else if (state == S_IDLE && wr && i_paddr == OFS_ADDR) begin
      cur_addr <= i_pwdata[AW-1:0];
    end else if (state == S_RESTORE && loc) begin
      cur_addr <= addr_step(t_addr, down, high);
    end
  end

  // ==========================================================
  // transaction issue, one per cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      mb.we <= 1'b0;
      mb.re <= 1'b0;
      mb.addr <= '0;
      mb.wdata <= '0;
      q_save <= 1'b0;
      q_cmp <= 1'b0;
      q_loc <= 1'b0;
      q_exp <= '0;
    end else begin
      mb.addr <= t_addr;
      q_loc <= loc;
      q_exp <= pat_of(pat, op[OP_INV]);
      mb.we <= (state == S_OPS && op[OP_WR]) || state == S_RESTORE;
      mb.re <= (state == S_OPS && op[OP_RD]) || state == S_SAVE;
      q_save <= state == S_SAVE;
      q_cmp <= state == S_OPS && op[OP_RD];
      // saved word may land in this very cycle, so bypass it
      if (state == S_RESTORE) begin
        mb.wdata <= (mb.rvalid && p_save && p_loc == loc) ?
                    mb.rdata : save[loc];
      end else begin
        mb.wdata <= pat_of(pat, op[OP_INV]);
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      p_save <= 1'b0;
      p_cmp <= 1'b0;
      p_loc <= 1'b0;
      p_exp <= '0;
      p_addr <= '0;
    end else begin
      p_save <= mb.re && q_save;
      p_cmp <= mb.re && q_cmp;
      p_loc <= q_loc;
      p_exp <= q_exp;
      p_addr <= mb.addr;
    end
  end

  // ==========================================================
  // checker and result flags
  assign err_set = mb.rvalid && p_cmp && mb.rdata != p_exp;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      save[0] <= '0;
      save[1] <= '0;
    end else if (mb.rvalid && p_save) begin
      save[p_loc] <= mb.rdata;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      done_st <= 1'b0;
      err_st <= 1'b0;
      err_addr <= '0;
      err_data <= '0;
    end else begin
      done_st <= done_set || (done_st && !(wr && i_paddr == OFS_STAT
                 && i_pwdata[STAT_DONE]));
      err_st <= err_set || (err_st && !(wr && i_paddr == OFS_STAT
                && i_pwdata[STAT_ERR]));
      if (err_set && !err_st) begin
        err_addr <= p_addr;
        err_data <= mb.rdata;
      end
    end
  end

  assign o_irq = irq_en && (done_st || err_st);
endmodule
`default_nettype wire

// ### verification/omb_properties.sv
// link checker: request, grant and transaction timing
`timescale 1ns/1ps
`default_nettype none
module omb_properties import omb_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic req,
  input wire logic ack,
  input wire logic [MSW-1:0] arr,
  input wire logic we,
  input wire logic re,
  input wire logic rvalid
);
  // ========
  // link rules
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  a_txn_needs_grant: assert property ((we || re) |-> req && ack)
    else $error("transfer without request and grant");
  a_read_in_burst: assert property (re |=> rvalid && req)
    else $error("read not returned inside the request");
  a_rvalid_has_cause: assert property (rvalid |-> $past(re))
    else $error("read data with no read");
  a_ack_needs_req: assert property (ack |-> $past(req))
    else $error("grant without request");
  a_ack_holds: assert property (req && ack |=> ack)
    else $error("grant dropped under request");
  a_unlock_on_drop: assert property ($fell(req) |=> !ack)
    else $error("lock kept after request fell");
  // off-line pass is the long case, well under this bound
  a_burst_ends: assert property ($rose(req) |-> ##[1:400] !req)
    else $error("request never withdrawn");
  a_ops_at_speed: assert property ($rose(ack) |-> ##[1:3] (we || re))
    else $error("no transfer soon after grant");
  a_target_steady: assert property (req && $past(req) |-> $stable(arr))
    else $error("array changed during request");
  cover property ($rose(ack));
  cover property ($fell(req));
  cover property (we ##1 re);
endmodule
`default_nettype wire

// ### verification/online_mbist_controller_tb.sv
// self-checking bench for the controller and core pair
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, ac) begin total_checks++; \
  if ((ac) !== (ex)) begin fails++; \
  $display("Error %s expected %0h seen %0h", nm, ex, ac); end end
module online_mbist_controller_tb import omb_pkg::*;;
  logic i_sys_clk, i_sys_rst, i_psel, i_penable, i_pwrite;
  logic [PAW-1:0] i_paddr;
  logic [PDW-1:0] i_pwdata, o_prdata;
  logic o_pready, o_pslverr, o_irq, o_busy;
  logic i_cpu_req, i_cpu_we, o_cpu_stall, o_cpu_refused, o_cpu_rvalid;
  logic [MSW-1:0] i_cpu_mem;
  logic [AW-1:0] i_cpu_addr, a;
  logic [DW-1:0] i_cpu_wdata, o_cpu_rdata, cpu_q, pat;
  logic [NMEM-1:0] i_mem_off;
  logic [DW-1:0] img [16];
  logic [31:0] seed, q;
  logic e, dn;
  int fails, total_checks, ack_cyc, req_cyc, cyc;

  omb_if link();
  omb_ctrl i_omb_ctrl (.i_sys_clk, .i_sys_rst, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .o_irq, .o_busy, .mb(link));
  omb_core i_omb_core (.i_sys_clk, .i_sys_rst, .mb(link), .i_cpu_req,
    .i_cpu_mem, .i_cpu_we, .i_cpu_addr, .i_cpu_wdata, .i_mem_off,
    .o_cpu_stall, .o_cpu_refused, .o_cpu_rvalid, .o_cpu_rdata);
  omb_properties i_omb_properties (.i_sys_clk, .i_sys_rst,
    .req(link.req), .ack(link.ack), .arr(link.arr), .we(link.we),
    .re(link.re), .rvalid(link.rvalid));

  always #4 i_sys_clk = ~i_sys_clk;

  // ========
  // cycle counts and hang guard
  always @(posedge i_sys_clk) begin
    cyc++;
    if (link.ack) ack_cyc++;
    if (link.req) req_cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end

  // ========
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // high address is all ones, so plain 4-bit wrap matches
  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] x,
      input logic d);
    return d ? x - 4'h1 : x + 4'h1;
  endfunction

  function automatic logic [31:0] cw(input logic off, input logic d);
    return {27'h0, 2'b01, d, off, 1'b1};
  endfunction

  task automatic tick();
    @(posedge i_sys_clk);
    #1;
  endtask

  task automatic apb(input logic w, input logic [PAW-1:0] ad,
      input logic [31:0] d);
    tick();
    i_psel = 1'b1;
    i_pwrite = w;
    i_paddr = ad;
    i_pwdata = d;
    tick();
    i_penable = 1'b1;
    @(negedge i_sys_clk);
    q = o_prdata;
    e = o_pslverr;
    `CHK("pready", 1'b1, o_pready)
    tick();
    i_psel = 1'b0;
    i_penable = 1'b0;
  endtask

  task automatic rd(input string nm, input logic [PAW-1:0] ad,
      input logic [31:0] ex);
    apb(1'b0, ad, 32'h0000_0000);
    `CHK(nm, ex, q)
  endtask

  task automatic cpu(input logic w, input logic [AW-1:0] ad,
      input logic [DW-1:0] d);
    int n;
    tick();
    i_cpu_req = 1'b1;
    i_cpu_mem = 1'b0;
    i_cpu_we = w;
    i_cpu_addr = ad;
    i_cpu_wdata = d;
    n = 0;
    @(negedge i_sys_clk);
    while (o_cpu_stall !== 1'b0 && n < 100) begin
      @(negedge i_sys_clk);
      n++;
    end
    if (n == 100) fails++;
    tick();
    i_cpu_req = 1'b0;
    cpu_q = o_cpu_rdata;
    `CHK("cpu_rvalid", !w, o_cpu_rvalid)
  endtask

  task automatic run(input logic [31:0] c);
    int n;
    ack_cyc = 0;
    apb(1'b1, OFS_CTRL, c);
    n = 0;
    tick();
    while (o_busy !== 1'b0 && n < 600) begin
      tick();
      n++;
    end
    if (n == 600) fails++;
  endtask

  task automatic chk_mem(input logic all_pat);
    for (int i = 0; i < 16; i++) begin
      cpu(1'b0, i[AW-1:0], 8'h00);
      `CHK("mem", all_pat ? pat : img[i], cpu_q)
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ========
  // main sequence
  initial begin
    seed = 32'h4ecc_707d;
    {i_sys_clk, i_psel, i_penable, i_pwrite, i_cpu_req, i_cpu_we} = '0;
    {i_paddr, i_pwdata, i_cpu_mem, i_cpu_addr, i_cpu_wdata} = '0;
    i_mem_off = '0;
    i_sys_rst = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
    i_sys_rst = 1'b0;
    rd("pid", OFS_PID, PID_VAL);
    rd("cid", OFS_CID, CID_VAL);
    rd("pat", OFS_PAT, {24'h00_0000, PAT_RST});
    rd("hole", 12'h100, 32'h0000_0000);
    `CHK("slverr", 1'b1, e)
    $display("reset values done");
    apb(1'b1, OFS_PROG0, 32'h0000_000A);
    run(cw(1'b0, 1'b0));
    repeat (8) tick();
    `CHK("unarmed", 0, req_cyc)
    rd("stat0", OFS_STAT, 32'h0000_0000);
    $display("unarmed start done");
    for (int i = 0; i < 16; i++) begin
      q = rnd();
      img[i] = q[7:0];
      cpu(1'b1, i[AW-1:0], img[i]);
    end
    apb(1'b1, OFS_ATTR, 32'h0000_000F);
    q = rnd();
    apb(1'b1, OFS_PAT, {24'h00_0000, q[7:0]});
    apb(1'b1, OFS_PROG0, 32'h0000_0001);
    apb(1'b1, OFS_PROG0 + 12'h004, 32'h0000_000A);
    for (int i = 0; i < 8; i++) begin
      q = rnd();
      a = (i == 0) ? 4'hF : (i == 1) ? 4'h0 : q[3:0];
      dn = (i == 1) ? 1'b1 : (i == 0) ? 1'b0 : q[4];
      apb(1'b1, OFS_ADDR, {28'h000_0000, a});
      run(cw(1'b0, dn));
      `CHK("burst_len", 1'b1, ack_cyc < 20)
      rd("addr", OFS_ADDR, {28'h000_0000, nxt(nxt(a, dn), dn)});
      rd("done", OFS_STAT, 32'h0000_000A);
      `CHK("irq_on", 1'b1, o_irq)
      apb(1'b1, OFS_STAT, 32'h0000_0002);
      `CHK("irq_off", 1'b0, o_irq)
    end
    chk_mem(1'b0);
    $display("on-line bursts done");
    // burst on the second array this time
    apb(1'b1, OFS_CTRL, cw(1'b0, 1'b0) | 32'h0000_0010);
    for (int n = 0; n < 50 && link.ack !== 1'b1; n++) tick();
    i_cpu_req = 1'b1;
    i_cpu_mem = 1'b1;
    @(negedge i_sys_clk);
    `CHK("stall_hit", 1'b1, o_cpu_stall)
    tick();
    i_cpu_mem = 1'b0;
    @(negedge i_sys_clk);
    `CHK("stall_other", 1'b0, o_cpu_stall)
    tick();
    i_cpu_req = 1'b0;
    // program writes while busy must be dropped
    apb(1'b1, OFS_PROG0, 32'h0000_000F);
    `CHK("busy", 1'b1, o_busy)
    run(cw(1'b0, 1'b0));
    rd("prog_lock", OFS_PROG0, 32'h0000_0001);
    apb(1'b1, OFS_STAT, 32'h0000_0002);
    $display("lock isolation done");
    apb(1'b0, OFS_ADDR, 32'h0000_0000);
    a = q[3:0];
    apb(1'b1, OFS_PAT, {24'h00_0000, ~img[a]});
    apb(1'b1, OFS_PROG0, 32'h0000_000A);
    run(cw(1'b0, 1'b0));
    rd("err", OFS_STAT, 32'h0000_000E);
    repeat (5) tick();
    rd("err_held", OFS_STAT, 32'h0000_000E);
    rd("eaddr", OFS_EADDR, {28'h000_0000, a});
    rd("edata", OFS_EDATA, {24'h00_0000, img[a]});
    `CHK("irq_err", 1'b1, o_irq)
    apb(1'b1, OFS_STAT, 32'h0000_0006);
    `CHK("irq_clr", 1'b0, o_irq)
    chk_mem(1'b0);
    $display("error capture done");
    tick();
    i_mem_off = 2'b01;
    i_cpu_req = 1'b1;
    i_cpu_mem = 1'b0;
    @(negedge i_sys_clk);
    `CHK("refused", 1'b1, o_cpu_refused)
    tick();
    i_cpu_req = 1'b0;
    q = rnd();
    pat = q[7:0];
    // inverted ops, so the array ends up holding pat
    apb(1'b1, OFS_PAT, {24'h00_0000, ~pat});
    apb(1'b1, OFS_PROG0, 32'h0000_0005);
    apb(1'b1, OFS_PROG0 + 12'h004, 32'h0000_000E);
    apb(1'b1, OFS_ADDR, 32'h0000_0000);
    run(cw(1'b1, 1'b0));
    rd("march", OFS_STAT, 32'h0000_000A);
    tick();
    i_mem_off = 2'b00;
    chk_mem(1'b1);
    $display("off-line march done");
    final_report();
  end
endmodule
`default_nettype wire
